// ### verilog/capture_compare_pwm_control.sv
`timescale 1ns/1ps
// Operation
// - control bit 7 enables the unit; zero disables it
// - control bit 5 shows the output level, read-only
// - control bit 4 picks left or right duty alignment in PWM mode
// - low nibble is the mode; codes 11xx select PWM
// - code 1011: pulse output and clear the 16-bit timer on match
// - code 1010: low-high-low pulse on match, timer not cleared
// - code 1001 clears output on match, 1000 sets it
// - code 0111 captures every 16th rising edge, 0110 every 4th
// - 0101 every rising, 0100 every falling, 0011 both edges capture
// - 0010 toggles on match; 0001 toggles and clears the timer
// - code 0000 turns everything off and holds internal state reset
// - two-bit time-base fields for units one and two, 11 reserved
// - bits 5-4 and 7-6 select time base for PWM three and four
// - capture loads timer low byte to low register, high to high
// - compare uses the 16-bit value pair against the timer
// - right alignment: duty from low byte and high bits 1:0
// - left alignment: duty from high byte and low bits 7:6
// - three-bit trigger selector picks pin, comparators, pin change, cells
// - trigger codes 110 and 111 connect nothing
// - reset zeroes registers and puts the pin into input mode
// - output is routed to generator, converter, timers, window, cells, pins
// - PWM timing counts only system clock based timer steps
// - control bit 6 and selector bits 7-3 read zero
// - period end sets output unless duty zero and latches duty
// - output clears when 10-bit time base equals buffered duty
// - compare match when value pair equals timer pair
module capture_compare_pwm_control
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // 16-bit timer
    input wire logic [15:0] sixteen_bit_timer,
    output logic timer_clear,
    // three period timers
    input period_timer_t period_timer [3],
    // capture trigger sources
    input wire logic unit_pin_in,
    input wire logic comparator_one_sync,
    input wire logic comparator_two_sync,
    input wire logic pin_change_interrupt,
    input wire logic logic_cell_one_out,
    input wire logic logic_cell_two_out,
    // pin control
    input wire logic pin_direction,
    output logic unit_pin_out,
    output logic unit_pin_oe,
    // internal routes of the output
    output logic waveform_generator_in,
    output logic converter_trigger,
    output logic period_timer_reset,
    output logic measurement_timer_window,
    output logic logic_cell_in,
    output logic pin_mapping_fabric_in,
    // time-base selections for the four channels
    output logic [1:0] unit_one_timer_sel,
    output logic [1:0] unit_two_timer_sel,
    output logic [1:0] pwm_three_timer_sel,
    output logic [1:0] pwm_four_timer_sel,
    // event request
    output logic event_request
);

    unit_state_t s_q;
    unit_state_t s_d;
    reg_req_t req;

    logic is_pwm;
    logic is_capture;
    logic is_compare;
    logic trig;
    logic rise;
    logic fall;
    logic cap_edge;
    logic cap_event;
    logic match;
    logic [1:0] unit_sel;
    period_timer_t tb;
    logic [9:0] duty_in;
    logic [9:0] base10;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // -----------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------
    // PWM occupies the whole upper quarter of codes
    assign is_pwm = s_q.enable && (s_q.mode[3:2] == 2'b11);
    assign is_capture = s_q.enable && (s_q.mode >= MODE_CAP_BOTH) && (s_q.mode <= MODE_CAP_RISE16);
    assign is_compare = s_q.enable && !is_pwm && !is_capture && (s_q.mode != MODE_OFF);

    // -----------------------------------------------------------------
    // capture trigger selection and edge detect
    // -----------------------------------------------------------------
    always_comb begin
        case (s_q.cap_sel)
            SRC_PIN: trig = unit_pin_in;
            SRC_CMP_ONE: trig = comparator_one_sync;
            SRC_CMP_TWO: trig = comparator_two_sync;
            SRC_PIN_CHANGE: trig = pin_change_interrupt;
            SRC_CELL_ONE: trig = logic_cell_one_out;
            SRC_CELL_TWO: trig = logic_cell_two_out;
            default: trig = s_q.trig_prev; // no source: no edge
        endcase
    end

    assign rise = trig && !s_q.trig_prev;
    assign fall = !trig && s_q.trig_prev;

    // edge that qualifies before the prescaler
    always_comb begin
        case (s_q.mode)
            MODE_CAP_BOTH: cap_edge = rise || fall;
            MODE_CAP_FALL: cap_edge = fall;
            MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16: cap_edge = rise;
            default: cap_edge = 1'b0;
        endcase
    end

    // prescaled capture event
    always_comb begin
        case (s_q.mode)
            MODE_CAP_RISE4: cap_event = is_capture && cap_edge && (s_q.prescale == PRESCALE_4_LAST);
            MODE_CAP_RISE16: cap_event = is_capture && cap_edge && (s_q.prescale == PRESCALE_16_LAST);
            default: cap_event = is_capture && cap_edge;
        endcase
    end

    // -----------------------------------------------------------------
    // compare and PWM time base
    // -----------------------------------------------------------------
    assign match = is_compare && ({s_q.val_hi, s_q.val_lo} == sixteen_bit_timer);

    // unit one uses the low field of the selector
    assign unit_sel = s_q.time_sel[1:0];
    always_comb begin
        case (unit_sel)
            2'b00: tb = period_timer[0];
            2'b01: tb = period_timer[1];
            2'b10: tb = period_timer[2];
            default: tb = '0; // reserved: no time base
        endcase
    end

    // duty layout from the value pair
    assign duty_in = s_q.align ? {s_q.val_hi, s_q.val_lo[7:6]}
                               : {s_q.val_hi[1:0], s_q.val_lo};
    assign base10 = {tb.count, tb.low_bits};

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = RESET_BYTE;
        s_d.trig_prev = trig;

        // register writes
        if (req.wr) begin
            case (req.addr)
                ADDR_UNIT_CONTROL: begin
                    // output bit and bit 6 are not writable
                    s_d.enable = req.wdata[CTRL_ENABLE_BIT];
                    s_d.align = req.wdata[CTRL_ALIGN_BIT];
                    s_d.mode = req.wdata[3:0];
                end
                ADDR_TIME_BASE_SELECT: s_d.time_sel = req.wdata;
                ADDR_VALUE_LOW_BYTE: s_d.val_lo = req.wdata;
                ADDR_VALUE_HIGH_BYTE: s_d.val_hi = req.wdata;
                ADDR_CAPTURE_SOURCE_SELECT: s_d.cap_sel = req.wdata[2:0];
                ADDR_EVENT_STATUS: s_d.event_flag = s_q.event_flag && !req.wdata[0];
                ADDR_EVENT_ENABLE: s_d.event_en = req.wdata[0];
                default: ;
            endcase
        end

        // capture prescaler counts qualifying edges
        if (is_capture && cap_edge) begin
            s_d.prescale = s_q.prescale + 4'h1;
        end

        // capture load overrides a write in the same cycle
        if (cap_event) begin
            // restart the edge count so that every 4th or 16th edge captures
            s_d.prescale = 4'h0;
            s_d.val_lo = sixteen_bit_timer[7:0];
            s_d.val_hi = sixteen_bit_timer[15:8];
        end

        // pulse modes fall back low one cycle after the match
        if (s_q.pulse_hold && !match) begin
            s_d.out_level = 1'b0;
            s_d.pulse_hold = 1'b0;
        end

        if (match) begin
            case (s_q.mode)
                MODE_CMP_TOGGLE, MODE_CMP_TOGGLE_CLR: s_d.out_level = !s_q.out_level;
                MODE_CMP_SET: s_d.out_level = 1'b1;
                MODE_CMP_CLEAR: s_d.out_level = 1'b0;
                MODE_CMP_PULSE, MODE_CMP_PULSE_CLR: begin
                    s_d.out_level = 1'b1;
                    s_d.pulse_hold = 1'b1;
                end
                default: ;
            endcase
        end

        // PWM: period end sets and reloads, duty match clears
        if (is_pwm) begin
            if (tb.period_end) begin
                s_d.duty_buf = duty_in;
                s_d.out_level = (duty_in != 10'h000);
            end else if (base10 == s_q.duty_buf) begin
                s_d.out_level = 1'b0;
            end
        end

        // event flag: set wins over a clear in the same cycle
        if (cap_event || match) begin
            s_d.event_flag = 1'b1;
        end

        // mode off or unit disabled holds the internals in reset
        if (!s_q.enable || s_q.mode == MODE_OFF || (req.wr && req.addr == ADDR_UNIT_CONTROL)) begin
            s_d.prescale = 4'h0;
        end
        if (!s_d.enable || s_d.mode == MODE_OFF) begin
            s_d.out_level = 1'b0;
            s_d.pulse_hold = 1'b0;
            s_d.duty_buf = 10'h000;
        end

        // read data for the next cycle
        if (req.rd) begin
            case (req.addr)
                ADDR_UNIT_CONTROL: s_d.rdata = {s_q.enable, 1'b0, s_q.out_level, s_q.align, s_q.mode};
                ADDR_TIME_BASE_SELECT: s_d.rdata = s_q.time_sel;
                ADDR_VALUE_LOW_BYTE: s_d.rdata = s_q.val_lo;
                ADDR_VALUE_HIGH_BYTE: s_d.rdata = s_q.val_hi;
                ADDR_CAPTURE_SOURCE_SELECT: s_d.rdata = {5'h00, s_q.cap_sel};
                ADDR_EVENT_STATUS: s_d.rdata = {7'h00, s_q.event_flag};
                ADDR_EVENT_ENABLE: s_d.rdata = {7'h00, s_q.event_en};
                default: s_d.rdata = RESET_BYTE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    // timer clear on match in the clearing compare modes
    assign timer_clear = match && (s_q.mode == MODE_CMP_PULSE_CLR || s_q.mode == MODE_CMP_TOGGLE_CLR);

    // pin drives only when enabled and software cleared the direction bit
    assign unit_pin_out = s_q.out_level;
    assign unit_pin_oe = s_q.enable && (s_q.mode != MODE_OFF) && !pin_direction && !is_capture;

    // internal destinations of the output level
    assign waveform_generator_in = s_q.out_level;
    assign converter_trigger = s_q.out_level;
    assign period_timer_reset = s_q.out_level;
    assign measurement_timer_window = s_q.out_level;
    assign logic_cell_in = s_q.out_level;
    assign pin_mapping_fabric_in = s_q.out_level;

    // selector fields for this and the other channels
    assign unit_one_timer_sel = s_q.time_sel[1:0];
    assign unit_two_timer_sel = s_q.time_sel[3:2];
    assign pwm_three_timer_sel = s_q.time_sel[5:4];
    assign pwm_four_timer_sel = s_q.time_sel[7:6];

    assign event_request = s_q.event_flag && s_q.event_en;

endmodule : capture_compare_pwm_control

// ### verilog/ccp_pkg.sv
package ccp_pkg;

    // ---------------------------------------------------------------
    // register map (word offsets on the plain register port)
    // ---------------------------------------------------------------
    localparam logic [2:0] ADDR_UNIT_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_TIME_BASE_SELECT = 3'h1;
    localparam logic [2:0] ADDR_VALUE_LOW_BYTE = 3'h2;
    localparam logic [2:0] ADDR_VALUE_HIGH_BYTE = 3'h3;
    localparam logic [2:0] ADDR_CAPTURE_SOURCE_SELECT = 3'h4;
    localparam logic [2:0] ADDR_EVENT_STATUS = 3'h5;
    localparam logic [2:0] ADDR_EVENT_ENABLE = 3'h6;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_OUTPUT_BIT = 5;
    localparam int CTRL_ALIGN_BIT = 4;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h9F;
    localparam logic [7:0] CAPSEL_WRITE_MASK = 8'h07;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ---------------------------------------------------------------
    // mode codes
    // ---------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE_CLR = 4'h1;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_PULSE = 4'hA;
    localparam logic [3:0] MODE_CMP_PULSE_CLR = 4'hB;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

    // capture source codes
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_CMP_ONE = 3'h1;
    localparam logic [2:0] SRC_CMP_TWO = 3'h2;
    localparam logic [2:0] SRC_PIN_CHANGE = 3'h3;
    localparam logic [2:0] SRC_CELL_ONE = 3'h4;
    localparam logic [2:0] SRC_CELL_TWO = 3'h5;

    // one period timer as seen by the unit
    typedef struct packed {
        logic [7:0] count;     // 8-bit timer value
        logic [1:0] low_bits;  // two clock or prescaler bits extending it
        logic period_end;      // pulse: increment after count equals period limit
    } period_timer_t;

    // register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // whole state of the unit
    typedef struct packed {
        logic enable;
        logic align;
        logic [3:0] mode;
        logic [7:0] time_sel;
        logic [7:0] val_lo;
        logic [7:0] val_hi;
        logic [2:0] cap_sel;
        logic out_level;
        logic trig_prev;
        logic [3:0] prescale;
        logic [9:0] duty_buf;
        logic pulse_hold;
        logic event_flag;
        logic event_en;
        logic [7:0] rdata;
    } unit_state_t;

endpackage : ccp_pkg

// ### testbench/ccp_props.sv
`timescale 1ns/1ps
module ccp_props
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pin, routes and selections
    input wire logic timer_clear,
    input wire logic pin_direction,
    input wire logic unit_pin_out,
    input wire logic unit_pin_oe,
    input wire logic waveform_generator_in,
    input wire logic converter_trigger,
    input wire logic period_timer_reset,
    input wire logic measurement_timer_window,
    input wire logic logic_cell_in,
    input wire logic pin_mapping_fabric_in,
    input wire logic [1:0] unit_one_timer_sel,
    input wire logic [1:0] unit_two_timer_sel,
    input wire logic [1:0] pwm_three_timer_sel,
    input wire logic [1:0] pwm_four_timer_sel,
    input wire logic event_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [7:0] sel_all;
    // all four time-base fields as one byte
    assign sel_all = {pwm_four_timer_sel, pwm_three_timer_sel, unit_two_timer_sel, unit_one_timer_sel};
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    rd_idle_zero_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero outside a read");
    out_bit_read_a: assert property (
        reg_rd && reg_addr == ADDR_UNIT_CONTROL |=> reg_rdata[5] == $past(unit_pin_out))
        else $error("output bit misread");
    ctrl_gap_zero_a: assert property (
        reg_rd && reg_addr == ADDR_UNIT_CONTROL |=> reg_rdata[6] == 1'b0) else $error("control bit 6 set");
    capsel_top_zero_a: assert property (
        reg_rd && reg_addr == ADDR_CAPTURE_SOURCE_SELECT |=> reg_rdata[7:3] == 5'h00)
        else $error("selector top bits set");
    tsel_write_a: assert property (
        reg_wr && reg_addr == ADDR_TIME_BASE_SELECT |=> sel_all == $past(reg_wdata))
        else $error("time base fields not written");
    // ---------------------------------------------------------------
    // pin and routes
    // ---------------------------------------------------------------
    route_copy_a: assert property (
        waveform_generator_in == unit_pin_out && pin_mapping_fabric_in == unit_pin_out
        && converter_trigger == unit_pin_out && period_timer_reset == unit_pin_out
        && measurement_timer_window == unit_pin_out && logic_cell_in == unit_pin_out)
        else $error("route differs from output");
    pin_input_only_a: assert property (
        unit_pin_oe |-> !pin_direction) else $error("pin driven while set as input");
    clear_drives_pin_a: assert property (
        timer_clear && !pin_direction |-> unit_pin_oe) else $error("compare mode not driving pin");
    reset_default_a: assert property (
        $rose(reset_n) |-> !unit_pin_oe && !event_request && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    cover property (timer_clear);
    cover property ($rose(unit_pin_out));
    cover property (reg_rd && reg_addr == ADDR_CAPTURE_SOURCE_SELECT);
endmodule : ccp_props

bind capture_compare_pwm_control ccp_props i_ccp_props (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .timer_clear, .pin_direction, .unit_pin_out, .unit_pin_oe, .waveform_generator_in,
    .converter_trigger, .period_timer_reset, .measurement_timer_window, .logic_cell_in,
    .pin_mapping_fabric_in, .unit_one_timer_sel, .unit_two_timer_sel, .pwm_three_timer_sel,
    .pwm_four_timer_sel, .event_request);

// ### testbench/ccp_partner.sv
`timescale 1ns/1ps
module ccp_partner
    import ccp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // controls
    input wire logic run,
    input wire logic timer_clear,
    // time bases
    output logic [15:0] sixteen_bit_timer,
    output period_timer_t period_timer [3]
);
    logic [1:0] phase_q;
    logic [7:0] cnt_q [3];
    // 16-bit timer: a clear from the unit wins, run low stalls it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sixteen_bit_timer <= 16'h0000;
        end else if (timer_clear) begin
            sixteen_bit_timer <= 16'h0000;
        end else if (run) begin
            sixteen_bit_timer <= sixteen_bit_timer + 16'h0001;
        end
    end
    // period timers step every fourth clock, limit 3 + index
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 2'h0;
            cnt_q <= '{8'h00, 8'h00, 8'h00};
        end else begin
            phase_q <= phase_q + 2'h1;
            for (int i = 0; i < 3; i++) begin
                if (phase_q == 2'h3) begin
                    cnt_q[i] <= (cnt_q[i] == 8'h03 + 8'(i)) ? 8'h00 : cnt_q[i] + 8'h01;
                end
            end
        end
    end
    // clock phase forms the two low time-base bits
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            period_timer[i] = '{cnt_q[i], phase_q, cnt_q[i] == 8'h00 && phase_q == 2'h0};
        end
    end
endmodule : ccp_partner

// ### testbench/capture_compare_pwm_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module capture_compare_pwm_control_tb_top
    import ccp_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] trig = 6'h00;
    logic pin_direction = 1'b0;
    logic run = 1'b1;
    logic [7:0] reg_rdata, d, rv;
    logic [15:0] tmr, t;
    logic [9:0] dt;
    logic timer_clear, unit_pin_out, unit_pin_oe, event_request, en, eo, ec, al;
    logic [3:0] md;
    logic [1:0] ts;
    period_timer_t ptim [3];
    int seed = 80291;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int clr_cnt = 0;
    int n, p, hc;
    // {enable, mode, expected output, expected timer clear}
    logic [6:0] cmp_tab [7] = '{7'b1_1000_1_0, 7'b1_1001_0_0, 7'b1_1010_0_0, 7'b1_1011_0_1, 7'b1_0010_1_0,
        7'b0_1000_0_0, 7'b1_0001_1_1};
    logic [3:0] cap_modes [5] = '{MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_BOTH, MODE_CAP_RISE4, MODE_CAP_RISE16};

    capture_compare_pwm_control i_capture_compare_pwm_control (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sixteen_bit_timer(tmr), .timer_clear, .period_timer(ptim), .unit_pin_in(trig[0]),
        .comparator_one_sync(trig[1]), .comparator_two_sync(trig[2]), .pin_change_interrupt(trig[3]),
        .logic_cell_one_out(trig[4]), .logic_cell_two_out(trig[5]), .pin_direction, .unit_pin_out, .unit_pin_oe,
        .waveform_generator_in(), .converter_trigger(), .period_timer_reset(), .measurement_timer_window(),
        .logic_cell_in(), .pin_mapping_fabric_in(), .unit_one_timer_sel(), .unit_two_timer_sel(),
        .pwm_three_timer_sel(), .pwm_four_timer_sel(), .event_request);
    ccp_partner i_ccp_partner (.mclk, .reset_n, .run, .timer_clear, .sixteen_bit_timer(tmr), .period_timer(ptim));

    // ---------------------------------------------------------------
    // clock, clear counter and hang limit
    // ---------------------------------------------------------------
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (timer_clear === 1'b1) clr_cnt++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // readback of a write made with the unit disabled
    function automatic logic [7:0] exp_rd(input logic [2:0] a, input logic [7:0] v);
        case (a)
            3'h0: return v & 8'h1F;
            3'h4: return v & 8'h07;
            3'h6: return v & 8'h01;
            3'h5, 3'h7: return 8'h00;
            default: return v;
        endcase
    endfunction : exp_rd

    // toggle the source 2k times, counting captures through the event flag
    task automatic run_cap(input logic [3:0] m, input logic [2:0] src, input int k);
        int caps;
        int want;
        caps = 0;
        want = src > 3'h5 ? 0 : m == MODE_CAP_BOTH ? 2 * k : m == MODE_CAP_RISE4 ? k / 4
            : m == MODE_CAP_RISE16 ? k / 16 : k;
        wr(ADDR_CAPTURE_SOURCE_SELECT, {5'h00, src});
        wr(ADDR_UNIT_CONTROL, {4'h8, m});
        repeat (2 * k) begin
            @(posedge mclk);
            trig <= trig ^ (src > 3'h5 ? 6'h3F : 6'h01 << src);
            repeat (4) @(posedge mclk);
            rd(ADDR_EVENT_STATUS, rv);
            if (rv[0] === 1'b1) begin
                caps++;
                wr(ADDR_EVENT_STATUS, 8'h01);
            end
        end
        `CHK(caps, want)
    endtask : run_cap

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), rv);
            `CHK(rv, 8'h00)
        end
        repeat (3) for (int a = 0; a < 8; a++) begin
            d = 8'($random(seed)) & (a == 0 ? 8'h7F : 8'hFF);
            wr(3'(a), d);
            rd(3'(a), rv);
            `CHK(rv, exp_rd(3'(a), d))
        end
        wr(ADDR_EVENT_ENABLE, 8'h01);
        foreach (cmp_tab[k]) begin
            {en, md, eo, ec} = cmp_tab[k];
            pin_direction <= 1'($random(seed));
            wr(ADDR_UNIT_CONTROL, {en, 3'b000, md});
            t = tmr + 16'd40;
            wr(ADDR_VALUE_LOW_BYTE, t[7:0]);
            wr(ADDR_VALUE_HIGH_BYTE, t[15:8]);
            n = clr_cnt;
            repeat (60) @(posedge mclk);
            #1;
            `CHK(unit_pin_out, eo)
            `CHK(clr_cnt != n, ec)
            `CHK(event_request, en)
            `CHK(unit_pin_oe, en & ~pin_direction)
            wr(ADDR_EVENT_STATUS, 8'h01);
        end
        foreach (cap_modes[k]) run_cap(cap_modes[k], 3'h0, 16);
        for (int s = 0; s < 8; s++) run_cap(MODE_CAP_RISE, 3'(s), 2);
        run <= 1'b0;
        wr(ADDR_CAPTURE_SOURCE_SELECT, 8'h00);
        wr(ADDR_UNIT_CONTROL, {4'h8, MODE_CAP_RISE});
        trig <= 6'h01;
        repeat (4) @(posedge mclk);
        rd(ADDR_VALUE_LOW_BYTE, rv);
        `CHK(rv, tmr[7:0])
        rd(ADDR_VALUE_HIGH_BYTE, rv);
        `CHK(rv, tmr[15:8])
        trig <= 6'h00;
        run <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            ts = 2'(k % 3);
            al = k > 2;
            p = 4 * (4 + k % 3);
            dt = k == 0 ? 10'h000 : 10'({$random(seed)} % p);
            rv = 8'($random(seed));
            wr(ADDR_TIME_BASE_SELECT, {rv[7:2], ts});
            wr(ADDR_UNIT_CONTROL, {3'b100, al, 2'b11, rv[1:0]});
            wr(ADDR_VALUE_LOW_BYTE, al ? {dt[1:0], rv[5:0]} : dt[7:0]);
            wr(ADDR_VALUE_HIGH_BYTE, al ? dt[9:2] : {rv[7:2], dt[9:8]});
            repeat (3 * p) @(posedge mclk);
            hc = 0;
            repeat (p) begin
                @(posedge mclk);
                #1 hc += (unit_pin_out === 1'b1);
            end
            `CHK(hc, int'(dt))
        end
        give_verdict();
    end
endmodule : capture_compare_pwm_control_tb_top
